// [inc/rmc_pkg.sv]
// Shared constants and types for the ramp and modulator configuration bank
package rmc_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [5:0] IDX_DWELL_UP_HI = 6'h10;
  localparam logic [5:0] IDX_DWELL_UP_LO = 6'h11;
  localparam logic [5:0] IDX_STEP_UP_HI = 6'h12;
  localparam logic [5:0] IDX_STEP_UP_LO = 6'h13;
  localparam logic [5:0] IDX_COUNT_UP_HI = 6'h14;
  localparam logic [5:0] IDX_COUNT_UP_LO = 6'h15;
  localparam logic [5:0] IDX_MOD_CFG = 6'h16;
  localparam logic [5:0] IDX_UNUSED = 6'h17;
  localparam logic [5:0] IDX_STEP_DN_HI = 6'h19;
  localparam logic [5:0] IDX_STEP_DN_LO = 6'h1A;
  localparam logic [5:0] IDX_SWEEP_CTRL = 6'h1B;
  // Storage slots, one per implemented register
  localparam int SLOTS = 10;
  localparam logic [3:0] SL_STEP_UP_HI = 4'h0;
  localparam logic [3:0] SL_STEP_UP_LO = 4'h1;
  localparam logic [3:0] SL_COUNT_HI = 4'h2;
  localparam logic [3:0] SL_COUNT_LO = 4'h3;
  localparam logic [3:0] SL_MOD_CFG = 4'h4;
  localparam logic [3:0] SL_STEP_DN_HI = 4'h5;
  localparam logic [3:0] SL_STEP_DN_LO = 4'h6;
  localparam logic [3:0] SL_DWELL_HI = 4'h7;
  localparam logic [3:0] SL_DWELL_LO = 4'h8;
  localparam logic [3:0] SL_SWEEP = 4'h9;
  // Field widths
  localparam int HI_W = 30;
  localparam int LO_W = 18;
  localparam int VAL_W = 48;
  localparam int CFG_W = 20;
  // Writable bits per slot, slot 9 first
  localparam logic [SLOTS-1:0][29:0] SLOT_MASK = {
    30'h00000001, 30'h0003FFFF, 30'h3FFFFFFF, 30'h0003FFFF, 30'h3FFFFFFF,
    30'h000FFFFF, 30'h0003FFFF, 30'h3FFFFFFF, 30'h0003FFFF, 30'h3FFFFFFF};
  // Reset values per slot, slot 9 first; symmetric sweep defaults on
  localparam logic [SLOTS-1:0][29:0] SLOT_RST = {
    30'h00000001, 30'h00000000, 30'h00000000, 30'h00000000, 30'h00000000,
    30'h00000000, 30'h00000000, 30'h00000000, 30'h00000000, 30'h00000000};
  // Modulator configuration field positions
  localparam int MC_ACC_LSB = 0;
  localparam int MC_FRAC_LSB = 6;
  localparam int MC_INT_LSB = 9;
  localparam int MC_MODE_A = 12;
  localparam int MC_MODE_B = 13;
  localparam int MC_INT_PATH = 15;
  localparam int MC_IN_BUF = 16;
  localparam int MC_OUT_BUF = 17;
  localparam int SWEEP_SYM_BIT = 0;
  // Accumulator width codes and their sizes in bits
  typedef enum logic [1:0] {
    ACCW_48 = 2'b00,
    ACCW_32 = 2'b01,
    ACCW_24 = 2'b10,
    ACCW_16 = 2'b11
  } rmc_accw_e;
  localparam logic [6:0] ACC_BITS_48 = 7'h30;
  localparam logic [6:0] ACC_BITS_32 = 7'h20;
  localparam logic [6:0] ACC_BITS_24 = 7'h18;
  localparam logic [6:0] ACC_BITS_16 = 7'h10;
  // Values handed to the ramp engine
  typedef struct packed {
    logic [VAL_W-1:0] step_up;
    logic [VAL_W-1:0] step_down;
    logic [VAL_W-1:0] count_up;
    logic [VAL_W-1:0] dwell_up;
    logic count_shared;
    logic dwell_shared;
  } rmc_ramp_s;
  // Values handed to the modulator
  typedef struct packed {
    logic [2:0][6:0] acc_bits;
    logic [2:0] frac_clk_en;
    logic [2:0] int_clk_en;
    logic mode_a_clk_en;
    logic mode_b_clk_en;
    logic int_path_clk_en;
    logic in_buf_clk_en;
    logic out_buf_clk_en;
  } rmc_mod_s;
endpackage

// [rtl/rmc_acc_width.sv]
// Accumulator width code to width in bits
`timescale 1ns/1ps
`default_nettype none
module rmc_acc_width (
  // Code in
  input wire logic [1:0] i_code,
  // Width out
  output logic [6:0] o_bits
);
  import rmc_pkg::*;
  rmc_accw_e code;
  assign code = rmc_accw_e'(i_code);
  // Plain lookup, no state
  always_comb
  begin
    case (code)
      ACCW_48: o_bits = ACC_BITS_48;
      ACCW_32: o_bits = ACC_BITS_32;
      ACCW_24: o_bits = ACC_BITS_24;
      default: o_bits = ACC_BITS_16;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/rmc_ahb_slave.sv]
// AHB-Lite front end: address phase capture, zero wait OKAY answers
`timescale 1ns/1ps
`default_nettype none
module rmc_ahb_slave (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // AHB-Lite address phase
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  // Answer
  output logic o_hreadyout,
  output logic o_hresp,
  // Register side
  output logic o_rd_en,
  output logic [5:0] o_rd_idx,
  output logic o_wr_en,
  output logic [5:0] o_wr_idx
);
  import rmc_pkg::*;
  logic valid;
  // Unaligned or high addresses are taken but hit nothing
  assign valid = i_hsel & i_htrans[1] & i_hready;
  assign o_rd_en = valid & ~i_hwrite;
  assign o_rd_idx = i_haddr[7:2];
  // Never stalls, so the write lands in the single data phase cycle
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wr_en <= 1'b0;
      o_wr_idx <= 6'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      o_wr_en <= valid & i_hwrite & (i_haddr[31:8] == 24'h000000)
                 & (i_haddr[1:0] == 2'h0);
      o_wr_idx <= i_haddr[7:2];
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/rmc_ramp_cfg.sv]
// Ramp parameter and modulator configuration register bank on AHB-Lite
//
// What this block does
// - Up/shared step size from 30+18 registers
// - Asymmetric: down step from down registers
// - Step count from 30+18 registers
// - Asymmetric: shared count covers upward only
// - Bits 1:0 pick first accumulator width
// - Bits 3:2, 5:4 pick other widths
// - Bits 8:6 stop fractional accumulator clocks
// - Bits 11:9 stop integer accumulator clocks
// - Bit 12 stops mode A clock
// - Bit 13 stops mode B clock
// - Bit 15 stops integer path clock
// - Bits 16, 17 stop buffer clocks
// - Index after modulator config holds nothing
// - Down step size from 30+18 registers
// - Symmetric bit, reset one, selects sharing
// - Dwell is split 30+18, shared when symmetric
`timescale 1ns/1ps
`default_nettype none
module rmc_ramp_cfg (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // To the ramp engine and the modulator
  output rmc_pkg::rmc_ramp_s o_ramp,
  output rmc_pkg::rmc_mod_s o_mod
);
  import rmc_pkg::*;

  logic rd_en;
  logic [5:0] rd_idx;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [29:0] store [SLOTS];
  logic rd_hit;
  logic [3:0] rd_slot;
  logic wr_hit;
  logic [3:0] wr_slot;
  logic fwd;
  logic [31:0] next_hrdata;
  logic sym;
  logic [VAL_W-1:0] step_up;
  logic [VAL_W-1:0] step_dn;
  logic [VAL_W-1:0] count_up;
  logic [VAL_W-1:0] dwell_up;
  logic [CFG_W-1:0] cfg;
  rmc_ramp_s next_ramp;
  rmc_mod_s next_mod;
  logic [2:0][6:0] acc_bits;

  // Bus front end; every transfer is a whole word, size is not checked
  rmc_ahb_slave u_bus (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_rd_en(rd_en),
    .o_rd_idx(rd_idx),
    .o_wr_en(wr_en),
    .o_wr_idx(wr_idx)
  );

  // Index to storage slot; anything else, 17h included, misses
  function automatic logic [4:0] slot_of(input logic [5:0] idx);
    logic [4:0] r;
    r = 5'h00;
    if (idx == IDX_STEP_UP_HI) r = {1'b1, SL_STEP_UP_HI};
    else if (idx == IDX_STEP_UP_LO) r = {1'b1, SL_STEP_UP_LO};
    else if (idx == IDX_COUNT_UP_HI) r = {1'b1, SL_COUNT_HI};
    else if (idx == IDX_COUNT_UP_LO) r = {1'b1, SL_COUNT_LO};
    else if (idx == IDX_MOD_CFG) r = {1'b1, SL_MOD_CFG};
    else if (idx == IDX_STEP_DN_HI) r = {1'b1, SL_STEP_DN_HI};
    else if (idx == IDX_STEP_DN_LO) r = {1'b1, SL_STEP_DN_LO};
    else if (idx == IDX_DWELL_UP_HI) r = {1'b1, SL_DWELL_HI};
    else if (idx == IDX_DWELL_UP_LO) r = {1'b1, SL_DWELL_LO};
    else if (idx == IDX_SWEEP_CTRL) r = {1'b1, SL_SWEEP};
    return r;
  endfunction

  // Address decode for both phases
  assign {rd_hit, rd_slot} = (i_haddr[31:8] == 24'h000000 && i_haddr[1:0] == 2'h0)
                             ? slot_of(rd_idx) : 5'h00;
  assign {wr_hit, wr_slot} = slot_of(wr_idx);

  // One flop row per register; unwritable bits stay zero
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_slot
      always_ff @(posedge i_mclk or negedge i_resetn)
      begin
        if (!i_resetn)
          store[g] <= SLOT_RST[g];
        else if (wr_en && wr_hit && wr_slot == 4'(g))
          store[g] <= i_hwdata[29:0] & SLOT_MASK[g];
      end
    end
  endgenerate

  // A read right behind a write to the same slot sees the new data,
  // since the write lands on the very edge the read data is captured
  assign fwd = wr_en && wr_hit && rd_hit && wr_slot == rd_slot;
  assign next_hrdata = !rd_hit ? 32'h00000000
                     : fwd ? {2'h0, i_hwdata[29:0] & SLOT_MASK[rd_slot]}
                     : {2'h0, store[rd_slot]};

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_hrdata <= 32'h00000000;
    else if (rd_en)
      o_hrdata <= next_hrdata;
  end

  // Split values joined with the upper register on top
  assign step_up = {store[SL_STEP_UP_HI], store[SL_STEP_UP_LO][LO_W-1:0]};
  assign count_up = {store[SL_COUNT_HI], store[SL_COUNT_LO][LO_W-1:0]};
  assign dwell_up = {store[SL_DWELL_HI], store[SL_DWELL_LO][LO_W-1:0]};
  assign step_dn = {store[SL_STEP_DN_HI], store[SL_STEP_DN_LO][LO_W-1:0]};
  assign sym = store[SL_SWEEP][SWEEP_SYM_BIT];
  assign cfg = store[SL_MOD_CFG][CFG_W-1:0];

  // Ramp engine view; down count and dwell live elsewhere when asymmetric
  always_comb
  begin
    next_ramp.step_up = step_up;
    next_ramp.step_down = sym ? step_up : step_dn;
    next_ramp.count_up = count_up;
    next_ramp.dwell_up = dwell_up;
    next_ramp.count_shared = sym;
    next_ramp.dwell_shared = sym;
  end

  // Width decode for the three accumulators
  generate
    for (g = 0; g < 3; g++)
    begin : g_acc
      rmc_acc_width u_w (
        .i_code(cfg[MC_ACC_LSB + 2*g +: 2]),
        .o_bits(acc_bits[g])
      );
    end
  endgenerate

  // Enables are the inverse of the stop bits; bits 14, 18, 19 drive nothing
  always_comb
  begin
    next_mod.acc_bits = acc_bits;
    next_mod.frac_clk_en = ~cfg[MC_FRAC_LSB +: 3];
    next_mod.int_clk_en = ~cfg[MC_INT_LSB +: 3];
    next_mod.mode_a_clk_en = ~cfg[MC_MODE_A];
    next_mod.mode_b_clk_en = ~cfg[MC_MODE_B];
    next_mod.int_path_clk_en = ~cfg[MC_INT_PATH];
    next_mod.in_buf_clk_en = ~cfg[MC_IN_BUF];
    next_mod.out_buf_clk_en = ~cfg[MC_OUT_BUF];
  end

  // Registered outputs; reset image matches the register reset values, sweep bit one
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ramp <= '{step_up: '0, step_down: '0, count_up: '0, dwell_up: '0,
                  count_shared: 1'b1, dwell_shared: 1'b1};
      o_mod <= '{acc_bits: {3{ACC_BITS_48}}, frac_clk_en: 3'h7, int_clk_en: 3'h7,
                 mode_a_clk_en: 1'b1, mode_b_clk_en: 1'b1, int_path_clk_en: 1'b1,
                 in_buf_clk_en: 1'b1, out_buf_clk_en: 1'b1};
    end
    else
    begin
      o_ramp <= next_ramp;
      o_mod <= next_mod;
    end
  end

  // Checks on the outputs against the stored words, on hole reads and on the stored configuration word
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  AST_STEP_UP_JOIN: assert property (
    ##1 o_ramp.step_up == {$past(store[SL_STEP_UP_HI]), $past(store[SL_STEP_UP_LO][17:0])})
    else $error("Up step not joined from its two registers");

  AST_STEP_DN_SRC: assert property (
    ##1 o_ramp.step_down == ($past(sym) ?
      {$past(store[SL_STEP_UP_HI]), $past(store[SL_STEP_UP_LO][17:0])} :
      {$past(store[SL_STEP_DN_HI]), $past(store[SL_STEP_DN_LO][17:0])}))
    else $error("Down step taken from the wrong registers");

  AST_COUNT_JOIN: assert property (
    ##1 o_ramp.count_up[47:18] == $past(store[SL_COUNT_HI]))
    else $error("Step count upper bits wrong");

  AST_COUNT_SHARED: assert property (
    $fell(sym) |=> !o_ramp.count_shared && !o_ramp.dwell_shared)
    else $error("Count still shared after leaving symmetric sweep");

  AST_ACC1_WIDTH: assert property (
    ##1 o_mod.acc_bits[0] == ($past(cfg[1:0]) == 2'h0 ? 7'h30 :
      $past(cfg[1:0]) == 2'h1 ? 7'h20 : $past(cfg[1:0]) == 2'h2 ? 7'h18 : 7'h10))
    else $error("First accumulator width mismatch");

  AST_ACC3_WIDTH: assert property (
    (cfg[5:4] == 2'h3) |=> o_mod.acc_bits[2] == 7'h10)
    else $error("Third accumulator width mismatch");

  AST_FRAC_GATE: assert property (
    ##1 (o_mod.frac_clk_en ^ $past(cfg[8:6])) == 3'h7)
    else $error("Fractional clock gate not the inverse of its field");

  AST_INT_GATE: assert property (
    ##1 (o_mod.int_clk_en ^ $past(cfg[11:9])) == 3'h7)
    else $error("Integer clock gate not the inverse of its field");

  AST_MODE_CLK: assert property (
    ##1 o_mod.mode_a_clk_en != $past(cfg[12]) && o_mod.mode_b_clk_en != $past(cfg[13]))
    else $error("Mode clock enable does not follow its stop bit");

  AST_BUF_CLK: assert property (
    ##1 o_mod.in_buf_clk_en != $past(cfg[16]) && o_mod.out_buf_clk_en != $past(cfg[17])
      && o_mod.int_path_clk_en != $past(cfg[15]))
    else $error("Buffer or integer path enable wrong");

  AST_HOLE_READ: assert property (
    (rd_en && i_haddr == 32'h0000005C) |=> o_hrdata == 32'h00000000)
    else $error("Unimplemented index read back non-zero");

  AST_WRITE_READBACK: assert property (
    (wr_en && wr_hit && wr_slot == SL_MOD_CFG) |=>
      store[SL_MOD_CFG] == ($past(i_hwdata[29:0]) & 30'h000FFFFF))
    else $error("Configuration word not stored as written");
endmodule
`default_nettype wire

// [tb/rmc_ramp_cfg_tb.sv]
// Self-checking bench for the ramp and modulator configuration bank
`timescale 1ns/1ps
`default_nettype none
module rmc_ramp_cfg_tb;
  import rmc_pkg::*;
  // Run length ceiling, well above the few hundred cycles the tests need
  localparam int LIMIT = 4000;
  // Index, writable mask and reset value of every implemented register
  localparam logic [5:0] RIDX [10] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h19,
    6'h1A, 6'h1B};
  localparam logic [31:0] RMSK [10] = '{32'h3FFFFFFF, 32'h0003FFFF, 32'h3FFFFFFF, 32'h0003FFFF,
    32'h3FFFFFFF, 32'h0003FFFF, 32'h000FFFFF, 32'h3FFFFFFF, 32'h0003FFFF, 32'h00000001};
  localparam logic [31:0] RRST [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h1};
  localparam logic [6:0] WBITS [4] = '{7'h30, 7'h20, 7'h18, 7'h10};
  // Bus drive and design outputs
  logic i_mclk, i_resetn, hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, cfg;
  logic [1:0] c0, c1, c2;
  rmc_ramp_s ramp;
  rmc_mod_s md;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  rmc_ramp_cfg i_dut (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_hsel(hsel),
    .i_haddr(haddr),
    .i_htrans(htrans),
    .i_hwrite(hwrite),
    .i_hsize(hsize),
    .i_hready(hready),
    .i_hwdata(hwdata),
    .o_hrdata(hrdata),
    .o_hreadyout(hready),
    .o_hresp(hresp),
    .o_ramp(ramp),
    .o_mod(md)
  );

  // Free-running 100 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] baddr(input logic [5:0] idx);
    return {24'h0, idx, 2'b00};
  endfunction

  // One single transfer; entered just after an edge, waits on hready, no cycle count assumed
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge i_mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_mclk); while (hready !== 1'b1);
    q = hrdata;
    chk(64'(hresp), 64'h0);
  endtask

  // Outputs follow a store one edge later; look after that edge has landed
  task automatic settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic do_reset;
    i_resetn <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
  endtask

  task automatic chk_defaults;
    for (int k = 0; k < 10; k++)
    begin
      xfer(baddr(RIDX[k]), 1'b0, 32'h0, rd);
      chk(64'(rd), 64'(RRST[k]));
    end
    chk(64'(ramp.step_up | ramp.step_down | ramp.count_up | ramp.dwell_up), 64'h0);
    chk(64'({ramp.count_shared, ramp.dwell_shared}), 64'h3);
    chk(64'(md), 64'({7'h30, 7'h30, 7'h30, 11'h7FF}));
  endtask

  // Main sequence
  initial
  begin
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    do_reset();
    chk_defaults();
    $display("test defaults done");
    // All-ones writes show which bits store, reserved ones included
    for (int k = 0; k < 10; k++)
    begin
      xfer(baddr(RIDX[k]), 1'b1, 32'hFFFFFFFF, rd);
      xfer(baddr(RIDX[k]), 1'b0, 32'h0, rd);
      chk(64'(rd), 64'(RMSK[k]));
    end
    $display("test masks done");
    // Split values, junk above the low width of the up step must be dropped
    xfer(baddr(IDX_STEP_UP_HI), 1'b1, 32'h2AAAAAAA, rd);
    xfer(baddr(IDX_STEP_UP_LO), 1'b1, 32'hFFFD5555, rd);
    xfer(baddr(IDX_COUNT_UP_HI), 1'b1, 32'h00000003, rd);
    xfer(baddr(IDX_COUNT_UP_LO), 1'b1, 32'h0003FFFF, rd);
    xfer(baddr(IDX_DWELL_UP_HI), 1'b1, 32'h00000001, rd);
    xfer(baddr(IDX_DWELL_UP_LO), 1'b1, 32'h00000002, rd);
    settle();
    chk(64'(ramp.step_up), 64'({30'h2AAAAAAA, 18'h15555}));
    chk(64'(ramp.step_down), 64'({30'h2AAAAAAA, 18'h15555}));
    chk(64'(ramp.count_up), 64'({30'h3, 18'h3FFFF}));
    chk(64'(ramp.dwell_up), 64'({30'h1, 18'h2}));
    // Asymmetric sweep takes the down step from its own pair
    xfer(baddr(IDX_SWEEP_CTRL), 1'b1, 32'h0, rd);
    xfer(baddr(IDX_STEP_DN_HI), 1'b1, 32'h12345678, rd);
    xfer(baddr(IDX_STEP_DN_LO), 1'b1, 32'h0002ABCD, rd);
    settle();
    chk(64'(ramp.step_down), 64'({30'h12345678, 18'h2ABCD}));
    chk(64'(ramp.step_up), 64'({30'h2AAAAAAA, 18'h15555}));
    chk(64'(ramp.count_up), 64'({30'h3, 18'h3FFFF}));
    chk(64'({ramp.count_shared, ramp.dwell_shared}), 64'h0);
    xfer(baddr(IDX_SWEEP_CTRL), 1'b1, 32'h1, rd);
    settle();
    chk(64'(ramp.step_down), 64'({30'h2AAAAAAA, 18'h15555}));
    $display("test ramp done");
    // Every width code in every accumulator field
    for (int c = 0; c < 4; c++)
    begin
      c0 = 2'(c);
      c1 = c0 + 2'h1;
      c2 = c0 + 2'h2;
      xfer(baddr(IDX_MOD_CFG), 1'b1, {26'h0, c2, c1, c0}, rd);
      settle();
      chk(64'(md.acc_bits), 64'({WBITS[c2], WBITS[c1], WBITS[c0]}));
    end
    // Walk one stop bit across the gate and reserved fields
    for (int b = 6; b < 20; b++)
    begin
      cfg = 32'h1 << b;
      xfer(baddr(IDX_MOD_CFG), 1'b1, cfg, rd);
      xfer(baddr(IDX_MOD_CFG), 1'b0, 32'h0, rd);
      chk(64'(rd), 64'(cfg));
      settle();
      // Enables are the stop bits inverted; XOR keeps the upper bits zero
      chk(64'({md.frac_clk_en, md.int_clk_en}),
        64'({cfg[8:6], cfg[11:9]} ^ 6'h3F));
      chk(64'({md.mode_a_clk_en, md.mode_b_clk_en}),
        64'({cfg[12], cfg[13]} ^ 2'h3));
      chk(64'({md.int_path_clk_en, md.in_buf_clk_en, md.out_buf_clk_en}),
        64'({cfg[15], cfg[16], cfg[17]} ^ 3'h7));
    end
    $display("test modulator done");
    // Hole after the config register and stray addresses hold nothing
    xfer(baddr(IDX_MOD_CFG), 1'b1, 32'h000ABCDE, rd);
    xfer(baddr(IDX_UNUSED), 1'b1, 32'hFFFFFFFF, rd);
    xfer(baddr(IDX_UNUSED), 1'b0, 32'h0, rd);
    chk(64'(rd), 64'h0);
    xfer(32'h00000158, 1'b1, 32'h0, rd);
    xfer(baddr(6'h3F), 1'b0, 32'h0, rd);
    chk(64'(rd), 64'h0);
    xfer(baddr(IDX_MOD_CFG), 1'b0, 32'h0, rd);
    chk(64'(rd), 64'h000ABCDE);
    $display("test unmapped done");
    // Reset in mid-run brings every default back
    do_reset();
    chk_defaults();
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
